/* include/csc_pkg.sv */
// constants, types and register map of the cpu core speed control
package csc_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [3:0] REG_SPEED     = 4'h0;
  localparam logic [3:0] REG_ISR_SPEED = 4'h1;
  localparam logic [3:0] REG_PLL       = 4'h2;
  localparam logic [3:0] REG_STATUS    = 4'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned F_DIV_LSB  = 0;
  localparam int unsigned F_SRC_LSB  = 8;
  localparam int unsigned F_OSC_OFF  = 10;
  localparam int unsigned F_PLL_OFF  = 11;
  localparam int unsigned F_AUTO     = 15;
  localparam int unsigned F_PRE_LSB  = 0;
  localparam int unsigned F_MULT_LSB = 4;
  localparam int unsigned F_POST_LSB = 12;
  localparam int unsigned F_READY    = 12;
  localparam int unsigned F_IN_ISR   = 13;
  localparam int unsigned F_PEND     = 14;
  localparam int unsigned F_HELD     = 15;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SPEED     = 16'h0000;
  localparam logic [15:0] RST_ISR_SPEED = 16'h0000;
  // pre 1, multiplier 50, post 1
  localparam logic [15:0] RST_PLL       = 16'h1321;

  localparam int unsigned DIV_MAX     = 128;
  localparam int unsigned DIV_W       = 7;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned PLL_REF_KHZ = 2000;
  localparam int unsigned PLL_OUT_KHZ = 100000;
  localparam int unsigned CLK_PERIOD_NS = 10;

  typedef enum logic [1:0] {SRC_MAIN, SRC_RTC, SRC_PLL, SRC_NONE} csc_src_t;

  typedef struct packed {
    logic             pll_off;
    logic             osc_off;
    csc_src_t         src;
    logic [DIV_W-1:0] div_m1;
  } csc_speed_t;

  typedef enum logic {ST_RUN, ST_HOLD} csc_state_t;

endpackage : csc_pkg

/* hw/csc_tick_div.sv */
// core clock enable divider that changes period only at a wrap
`timescale 1ns/1ns
module csc_tick_div
#(
  parameter int unsigned DIV_W = 7
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] div_m1,
  output logic                  tick
);

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;

  if (DIV_W < 1 || DIV_W > 16)
  begin : g_bad_width
    $error("csc_tick_div: DIV_W out of range");
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // the divisor is only sampled at the wrap, so a running period is
  // never cut short when software picks a new one
  always_comb
  begin
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (run)
    begin
      if (cnt_reg == '0)
      begin
        tick_next = 1'b1;
        cnt_next  = div_m1;
      end
      else
      begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : csc_tick_div

/* hw/csc_speed_ctrl.sv */
// cpu core clock source and speed control with automatic isr speed
//
// Notes on behaviour
// RULE1: core clock divisor is programmable over every value from 1 to 128.
// RULE2: divisor gates only the core clock; timers keep the undivided clock.
// RULE3: speed setting selects main oscillator, real-time oscillator or pll.
// RULE4: speed setting can disable the main oscillator or the pll.
// RULE5: speed setting completes at the old divisor; new one applies later.
// RULE6: core speed changes automatically on isr entry and on isr return.
// RULE7: pll has pre and post dividers; 2 MHz input gives 100 MHz.
// RULE8: switches never shorten clock phases; core clock held until stable.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ns
module csc_speed_ctrl
  import csc_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic [csc_pkg::ADDR_W-1:0] addr,
  input  wire logic [csc_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [csc_pkg::DATA_W-1:0] rd_data,
  input  wire logic                       main_osc_stable,
  input  wire logic                       realtime_osc_stable,
  input  wire logic                       pll_lock,
  input  wire logic                       isr_enter,
  input  wire logic                       isr_return,
  output logic                            core_clk_en,
  output logic                            timer_clk_en,
  output csc_pkg::csc_src_t               clk_src_sel,
  output logic                            main_osc_en,
  output logic                            pll_en,
  output logic      [3:0]                 pll_pre_div,
  output logic      [7:0]                 pll_mult,
  output logic      [3:0]                 pll_post_div,
  output logic                            core_clk_held
);

  import csc_pkg::*;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic csc_speed_t to_speed(input logic [15:0] w);
    csc_speed_t s;
    s.div_m1  = w[F_DIV_LSB +: DIV_W];
    s.src     = csc_src_t'(w[F_SRC_LSB +: 2]);
    s.osc_off = w[F_OSC_OFF];
    s.pll_off = w[F_PLL_OFF];
    return s;
  endfunction : to_speed

  function automatic logic [15:0] from_speed(input csc_speed_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[F_DIV_LSB +: DIV_W] = s.div_m1;
    w[F_SRC_LSB +: 2]     = s.src;
    w[F_OSC_OFF]          = s.osc_off;
    w[F_PLL_OFF]          = s.pll_off;
    return w;
  endfunction : from_speed

  // the pll runs from the main oscillator, so it needs both enabled
  function automatic logic src_ok(input csc_speed_t s,
                                  input logic [2:0] st);
    logic ok;
    ok = 1'b0;
    case (s.src)
      SRC_MAIN: ok = st[0] && !s.osc_off;
      SRC_RTC:  ok = st[1];
      SRC_PLL:  ok = st[2] && !s.osc_off && !s.pll_off;
      default:  ok = 1'b0;
    endcase
    return ok;
  endfunction : src_ok

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_in;
  logic [2:0] stable_reg;
  logic [2:0] stable_next;

  assign pin_in = {pll_lock, realtime_osc_stable, main_osc_stable};

  for (genvar i = 0; i < 3; i++)
  begin : g_sync
    logic [SYNC_STAGES-1:0] sh_reg;
    always_ff @(posedge ref_clk)
    begin
      if (rst)
        sh_reg <= '0;
      else
        sh_reg <= {sh_reg[SYNC_STAGES-2:0], pin_in[i]};
    end
    always_comb
    begin
      stable_next[i] = stable_reg[i];
      if (sh_reg[1] == sh_reg[2])
        stable_next[i] = sh_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  csc_speed_t  speed_reg,    speed_next;
  csc_speed_t  isr_reg,      isr_next;
  logic        auto_reg,     auto_next;
  logic [15:0] pll_reg,      pll_next;
  csc_speed_t  active_reg,   active_next;
  csc_speed_t  pend_reg,     pend_next;
  logic        pend_vld_reg, pend_vld_next;
  logic        in_isr_reg,   in_isr_next;
  csc_state_t  state_reg,    state_next;
  logic [15:0] rd_reg,       rd_next;
  logic        osc_en_reg,   pll_en_reg;
  logic        held_reg,     timer_reg;
  logic        ready;
  logic        run;
  logic        apply;
  logic        wr_speed;

  assign ready    = src_ok(active_reg, stable_reg);
  assign run      = (state_reg == ST_RUN) && ready;                 // RULE8
  // a pending setting lands after the current core period ends, or at once in ST_HOLD
  assign apply    = pend_vld_reg && (core_clk_en || state_reg == ST_HOLD);
  assign wr_speed = wr_en && addr == REG_SPEED;

  always_comb
  begin
    speed_next    = speed_reg;
    isr_next      = isr_reg;
    auto_next     = auto_reg;
    pll_next      = pll_reg;
    active_next   = active_reg;
    pend_next     = pend_reg;
    pend_vld_next = pend_vld_reg;
    in_isr_next   = in_isr_reg;
    state_next    = state_reg;
    rd_next       = 16'h0000;
    if (apply)
    begin
      active_next   = pend_reg;                                     // RULE5
      pend_vld_next = 1'b0;
    end
    if (wr_en)
    begin
      case (addr)
        REG_SPEED:
        begin
          speed_next = to_speed(wr_data);                  // RULE1 RULE3 RULE4
          if (!in_isr_reg)
          begin
            pend_next     = speed_next;                             // RULE5
            pend_vld_next = 1'b1;
          end
        end
        REG_ISR_SPEED:
        begin
          isr_next  = to_speed(wr_data);
          auto_next = wr_data[F_AUTO];
        end
        REG_PLL: pll_next = wr_data;                                // RULE7
        default: ;
      endcase
    end
    // later events override earlier ones so a new setting is never lost
    if (isr_enter && auto_reg && !in_isr_reg)
    begin
      pend_next     = isr_reg;                                      // RULE6
      pend_vld_next = 1'b1;
      in_isr_next   = 1'b1;
    end
    else if (isr_return && in_isr_reg)
    begin
      pend_next     = speed_next;                                   // RULE6
      pend_vld_next = 1'b1;
      in_isr_next   = 1'b0;
    end
    case (state_reg)
      ST_RUN:  if (!ready) state_next = ST_HOLD;                    // RULE8
      ST_HOLD: if (ready && !apply) state_next = ST_RUN;
      default: state_next = ST_HOLD;
    endcase
    if (rd_en)
    begin
      case (addr)
        REG_SPEED:     rd_next = from_speed(speed_reg);
        REG_ISR_SPEED:
        begin
          rd_next         = from_speed(isr_reg);
          rd_next[F_AUTO] = auto_reg;
        end
        REG_PLL:       rd_next = pll_reg;
        REG_STATUS:
        begin
          rd_next           = from_speed(active_reg);
          rd_next[F_READY]  = ready;
          rd_next[F_IN_ISR] = in_isr_reg;
          rd_next[F_PEND]   = pend_vld_reg;
          rd_next[F_HELD]   = held_reg;
        end
        default:       rd_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      speed_reg    <= to_speed(RST_SPEED);
      isr_reg      <= to_speed(RST_ISR_SPEED);
      auto_reg     <= RST_ISR_SPEED[F_AUTO];
      pll_reg      <= RST_PLL;
      active_reg   <= to_speed(RST_SPEED);
      pend_reg     <= to_speed(RST_SPEED);
      pend_vld_reg <= 1'b0;
      in_isr_reg   <= 1'b0;
      state_reg    <= ST_HOLD;
      rd_reg       <= 16'h0000;
      stable_reg   <= 3'h0;
      osc_en_reg   <= 1'b1;
      pll_en_reg   <= 1'b1;
      held_reg     <= 1'b1;
      timer_reg    <= 1'b0;
    end
    else
    begin
      speed_reg    <= speed_next;
      isr_reg      <= isr_next;
      auto_reg     <= auto_next;
      pll_reg      <= pll_next;
      active_reg   <= active_next;
      pend_reg     <= pend_next;
      pend_vld_reg <= pend_vld_next;
      in_isr_reg   <= in_isr_next;
      state_reg    <= state_next;
      rd_reg       <= rd_next;
      stable_reg   <= stable_next;
      osc_en_reg   <= !active_next.osc_off;                         // RULE4
      pll_en_reg   <= !active_next.pll_off;                         // RULE4
      held_reg     <= (state_next == ST_HOLD);
      timer_reg    <= 1'b1;                                         // RULE2
    end
  end

  // ----------------------------------------------------------------
  // divider and outputs
  // ----------------------------------------------------------------
  csc_tick_div #(.DIV_W(DIV_W)) u_div (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (run),
    .div_m1  (active_reg.div_m1),                                   // RULE1
    .tick    (core_clk_en)
  );

  assign rd_data       = rd_reg;
  assign timer_clk_en  = timer_reg;                                 // RULE2
  assign clk_src_sel   = active_reg.src;                            // RULE3
  assign main_osc_en   = osc_en_reg;
  assign pll_en        = pll_en_reg;
  assign pll_pre_div   = pll_reg[F_PRE_LSB +: 4];                   // RULE7
  assign pll_mult      = pll_reg[F_MULT_LSB +: 8];
  assign pll_post_div  = pll_reg[F_POST_LSB +: 4];
  assign core_clk_held = held_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [7:0] gap_reg;
  logic [7:0] gap_next;

  always_comb
  begin
    gap_next = gap_reg;
    if (core_clk_en || !run)
      gap_next = 8'h00;
    else if (gap_reg != 8'hFF)
      gap_next = gap_reg + 8'h01;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      gap_reg <= 8'h00;
    else
      gap_reg <= gap_next;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_div_max_gap: assert property (gap_reg <= 8'h80) // RULE1
    else $error("core clock gap exceeds largest divisor");
  chk_div_one_rate: assert property (
    core_clk_en && run && active_reg.div_m1 == 7'h00 && !pend_vld_reg
    |=> core_clk_en) // RULE1
    else $error("divisor one does not tick every cycle");
  chk_timer_free: assert property (
    !$past(rst) && !core_clk_en |-> timer_clk_en) // RULE2
    else $error("timer clock stopped with core clock");
  chk_src_follow: assert property (
    apply |=> clk_src_sel == $past(pend_reg.src)) // RULE3
    else $error("clock source not taken from setting");
  chk_osc_disable: assert property (
    apply && pend_reg.osc_off |=> !main_osc_en) // RULE4
    else $error("main oscillator not disabled");
  chk_old_div_kept: assert property (
    wr_speed && !pend_vld_reg |=> active_reg == $past(active_reg)) // RULE5
    else $error("new divisor applied during speed write");
  chk_isr_speed: assert property (
    isr_enter && auto_reg && !in_isr_reg
    |=> pend_vld_reg && in_isr_reg && pend_reg == $past(isr_reg)) // RULE6
    else $error("isr entry did not request isr speed");
  chk_isr_restore: assert property (
    isr_return && in_isr_reg && !wr_speed
    |=> !in_isr_reg && pend_reg == $past(speed_reg)) // RULE6
    else $error("isr return did not restore speed");
  chk_pll_ratio: assert property (
    pll_reg == RST_PLL |-> PLL_REF_KHZ * pll_mult
    == PLL_OUT_KHZ * pll_pre_div * pll_post_div) // RULE7
    else $error("pll default ratio wrong");
  chk_hold_clock: assert property (
    !ready |=> !core_clk_en ##1 !core_clk_en) // RULE8
    else $error("core clock ran on unstable source");

  cov_isr_round: cover property (isr_enter && auto_reg ##[1:50] isr_return);
  cov_hold_exit: cover property (held_reg ##1 !held_reg);
  cov_div_change: cover property (apply && pend_reg.div_m1 == 7'h7F);

endmodule : csc_speed_ctrl

/* tb/tb_top.sv */
// self-checking bench for the cpu core speed control
`timescale 1ns/1ns
module tb_top;
  import csc_pkg::*;

  logic        ref_clk, rst, wr_en, rd_en, isr_enter, isr_return;
  logic [3:0]  addr, pre, post;
  logic [7:0]  mult;
  logic [15:0] wr_data, rd_data, mdl_spd, v;
  logic        osc_ok, rtc_ok, lock_ok, osc_run, lock_run, twatch;
  logic        core_clk_en, timer_clk_en, main_osc_en, pll_en, held;
  csc_src_t    clk_src_sel;
  int          n_errors, n_compared, cyc, per, i, d, t;
  int          exp_q[$];

  csc_speed_ctrl csc_speed_ctrl_i
  (
    .ref_clk             (ref_clk),
    .rst                 (rst),
    .addr                (addr),
    .wr_data             (wr_data),
    .wr_en               (wr_en),
    .rd_en               (rd_en),
    .rd_data             (rd_data),
    .main_osc_stable     (osc_ok),
    .realtime_osc_stable (rtc_ok),
    .pll_lock            (lock_ok),
    .isr_enter           (isr_enter),
    .isr_return          (isr_return),
    .core_clk_en         (core_clk_en),
    .timer_clk_en        (timer_clk_en),
    .clk_src_sel         (clk_src_sel),
    .main_osc_en         (main_osc_en),
    .pll_en              (pll_en),
    .pll_pre_div         (pre),
    .pll_mult            (mult),
    .pll_post_div        (post),
    .core_clk_held       (held)
  );

  // ----------------------------------------------------------------
  // clock and oscillator model
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // a disabled oscillator loses its stable flag; pll needs the main one
  always @(posedge ref_clk)
  begin
    osc_ok  <= main_osc_en & osc_run;
    rtc_ok  <= 1'b1;
    lock_ok <= pll_en & main_osc_en & lock_run;
  end

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    n_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
      fail($sformatf("word %h expected %h", g, e));
  endtask : chk_word

  task automatic chk_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e)
      fail($sformatf("flag %b expected %b", g, e));
  endtask : chk_bit

  task automatic chk_per(input int g, input int e);
    n_compared++;
    if (g != e)
      fail($sformatf("period %0d expected %0d", g, e));
  endtask : chk_per

  task automatic print_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // timers must see every cycle; the ceiling cuts a hang short
  always @(posedge ref_clk)
  begin
    cyc++;
    if (twatch)
      chk_bit(timer_clk_en, 1'b1);
    if (cyc == 60000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // bus, event and measuring tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= dat;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 chk_word(rd_data, e);
    @(posedge ref_clk);
    #1 chk_word(rd_data, 16'h0000);
  endtask : rd_chk

  task automatic pulse(input logic ret);
    @(posedge ref_clk);
    isr_enter  <= ~ret;
    isr_return <= ret;
    @(posedge ref_clk);
    isr_enter  <= 1'b0;
    isr_return <= 1'b0;
  endtask : pulse

  task automatic wait_tick;
    int k;
    for (k = 0; k < 400; k++)
    begin
      @(posedge ref_clk);
      if (core_clk_en === 1'b1)
        break;
    end
    if (k == 400)
      fail("no core tick");
  endtask : wait_tick

  task automatic measure(output int n);
    int k;
    wait_tick();
    for (k = 1; k < 400; k++)
    begin
      @(posedge ref_clk);
      if (core_clk_en === 1'b1)
        break;
    end
    n = k;
  endtask : measure

  // the old period runs out and one more old period follows an apply
  task automatic steady(input int e);
    int p;
    repeat (3) wait_tick();
    measure(p);
    chk_per(p, e);
    measure(p);
    chk_per(p, e);
  endtask : steady

  function automatic logic [15:0] spd(input int dv, input int s,
                                      input logic oo, input logic po);
    spd = {4'h0, po, oo, 2'(s), 1'b0, 7'(dv - 1)};
  endfunction : spd

  function automatic logic [15:0] st(input logic isr, input logic rdy,
                                     input logic hld);
    st = {hld, 1'b0, isr, rdy, mdl_spd[11:0]};
  endfunction : st

  task automatic set_spd(input int dv, input int s, input logic oo,
                         input logic po);
    mdl_spd = spd(dv, s, oo, po);
    wr(REG_SPEED, mdl_spd);
  endtask : set_spd

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst, osc_run, lock_run} = 3'h7;
    {wr_en, rd_en, isr_enter, isr_return, twatch} = 5'h00;
    addr    = 4'h0;
    wr_data = 16'h0000;
    mdl_spd = 16'h0000;
    void'($urandom(32'h71AC));
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk_bit(main_osc_en, 1'b1);
    chk_bit(pll_en, 1'b1);
    chk_word({post, mult, pre}, RST_PLL);
    chk_word({14'h0000, clk_src_sel}, 16'h0000);
    repeat (2) @(posedge ref_clk);
    #1 twatch = 1'b1;
    rd_chk(REG_SPEED, RST_SPEED);
    rd_chk(REG_ISR_SPEED, RST_ISR_SPEED);
    rd_chk(REG_PLL, RST_PLL);
    rd_chk(4'h9, 16'h0000);
    v = 16'($urandom());
    wr(REG_PLL, v);
    rd_chk(REG_PLL, v);
    chk_word({post, mult, pre}, v);
    wr(REG_PLL, RST_PLL);
    wr(REG_STATUS, 16'hFFFF);
    rd_chk(REG_STATUS, st(1'b0, 1'b1, 1'b0));
    // boundary divisors first, then random ones
    for (i = 0; i < 5; i++)
    begin
      d = (i == 0) ? 1 : (i == 1) ? 128 : (i == 2) ? 2
          : 3 + $urandom_range(124);
      set_spd(d, 0, 1'b0, 1'b0);
      exp_q.push_back(d);
      steady(exp_q.pop_front());
      rd_chk(REG_STATUS, st(1'b0, 1'b1, 1'b0));
    end
    set_spd(8, 0, 1'b0, 1'b0);
    steady(8);
    wait_tick();
    set_spd(3, 0, 1'b0, 1'b0);
    // the write lands mid period: one full old period follows the apply
    exp_q = {8, 3};
    measure(per);
    chk_per(per, exp_q.pop_front());
    steady(exp_q.pop_front());
    for (i = 0; i < 3; i++)
    begin
      set_spd(4, i, 1'b0, 1'b0);
      steady(4);
      chk_word({14'h0000, clk_src_sel}, 16'(i));
    end
    set_spd(4, 1, 1'b1, 1'b0);
    steady(4);
    chk_bit(main_osc_en, 1'b0);
    chk_bit(pll_en, 1'b1);
    set_spd(4, 1, 1'b1, 1'b1);
    steady(4);
    chk_bit(pll_en, 1'b0);
    set_spd(4, 0, 1'b0, 1'b0);
    steady(4);
    lock_run <= 1'b0;
    set_spd(4, 2, 1'b0, 1'b0);
    repeat (30) @(posedge ref_clk);
    t = 0;
    for (i = 0; i < 20; i++)
    begin
      @(posedge ref_clk);
      if (core_clk_en === 1'b1)
        t++;
    end
    chk_per(t, 0);
    chk_bit(held, 1'b1);
    rd_chk(REG_STATUS, st(1'b0, 1'b0, 1'b1));
    lock_run <= 1'b1;
    steady(4);
    chk_bit(held, 1'b0);
    set_spd(5, 0, 1'b0, 1'b0);
    steady(5);
    wr(REG_ISR_SPEED, 16'h8000 | spd(2, 0, 1'b0, 1'b0));
    rd_chk(REG_ISR_SPEED, 16'h8000 | spd(2, 0, 1'b0, 1'b0));
    pulse(1'b0);
    steady(2);
    v = mdl_spd;
    mdl_spd = spd(2, 0, 1'b0, 1'b0);
    rd_chk(REG_STATUS, st(1'b1, 1'b1, 1'b0));
    rd_chk(REG_SPEED, v);
    wr(REG_SPEED, spd(7, 0, 1'b0, 1'b0));
    rd_chk(REG_SPEED, spd(7, 0, 1'b0, 1'b0));
    steady(2);
    pulse(1'b1);
    steady(7);
    mdl_spd = spd(7, 0, 1'b0, 1'b0);
    wr(REG_ISR_SPEED, spd(2, 0, 1'b0, 1'b0));
    pulse(1'b0);
    steady(7);
    rd_chk(REG_STATUS, st(1'b0, 1'b1, 1'b0));
    print_verdict();
  end

endmodule : tb_top
